// *** inc/scgt_pkg.sv ***
/*
  Constants for the smart card guard and waiting timers: register addresses,
  reset values, field positions and guard-time floors.
  Assumes an 8-bit register port in the upper external data space.
*/
package scgt_pkg;
  localparam logic [15:0] ADDR_BGUARD = 16'hFE16;
  localparam logic [15:0] ADDR_XGUARD = 16'hFE17;
  localparam logic [15:0] ADDR_BW3 = 16'hFE18;
  localparam logic [15:0] ADDR_BW2 = 16'hFE19;
  localparam logic [15:0] ADDR_BW1 = 16'hFE1A;
  localparam logic [15:0] ADDR_BW0 = 16'hFE1B;
  localparam logic [15:0] ADDR_CWH = 16'hFE1C;
  localparam logic [15:0] ADDR_CWL = 16'hFE1D;
  localparam logic [7:0] XGUARD_RST = 8'h0C;
  localparam logic [7:0] BGUARD_RST = 8'h10;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int XGUARD_MSB_BIT = 7;
  localparam int BGUARD_W = 5;
  localparam logic [3:0] BW3_MASK = 4'hF;
  localparam logic [8:0] XGUARD_MIN_T0 = 9'h00C;
  localparam logic [8:0] XGUARD_MIN_T1 = 9'h00B;
  localparam int BW_W = 28;
  localparam int CW_W = 16;
endpackage : scgt_pkg

// *** design/scgt_etu_timer.sv ***
/*
  One ETU-driven timeout counter used for both waiting timers.
  Assumes the ETU tick is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ns
module scgt_etu_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic etu_tick,
  input wire logic arm,
  input wire logic restart,
  input wire logic stop,
  input wire logic [W-1:0] limit,
  output logic timeout
);
  typedef struct packed {
    logic run;
    logic [W-1:0] cnt;
    logic tout;
  } scgt_tmr_t;
  scgt_tmr_t st_r;
  scgt_tmr_t st_nxt;

  // Restart clears the count; a single timeout pulse fires when limit is reached.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tout = 1'b0;
    if (stop) begin
      st_nxt.run = 1'b0;
    end else if (restart || arm) begin
      st_nxt.run = 1'b1;
      st_nxt.cnt = '0;
    end else if (st_r.run && etu_tick) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
      if (st_nxt.cnt == limit && limit != '0) begin
        st_nxt.tout = 1'b1;
        st_nxt.run = 1'b0;
      end
    end
  end

  // State register; a zero limit is treated as disabled so a wrapped count never fires.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timeout = st_r.tout;
endmodule : scgt_etu_timer

// *** design/scgt_timers.sv ***
/*
  Guard and waiting timers of the smart card character link, with their
  byte registers on the CPU's external data port.
  Assumes the character engine reports start-bit leading edges as one-cycle
  pulses, provides the ETU tick, and waits while tx_hold is high.
*/
`timescale 1ns/1ns
// Function
// - In transmit mode consecutive sent start bits are spaced by at least the guard value.
// - The guard register resets to 12 and spacing never drops below 12 (T=0) or 11 (T=1).
// - Under T=0 a break from the card postpones the next transmitted start bit.
// - A 28-bit waiting value lives in four byte registers, low byte 0xFE1B, top at 0xFE18.
// - Under T=1 the waiting timer runs from last sent character to first received start.
// - Under T=0 the waiting value bounds spacing of any two consecutive characters.
// - The 28-bit waiting timer is wide enough for a waiting time extension.
// - A 16-bit character/initial limit lives at 0xFE1D (low) and 0xFE1C (high).
// - The 16-bit timer measures between consecutive received start bits.
// - Either timer running out raises an interrupt request to firmware.
// - The guard low byte sits at 0xFE17 and resets to 0x0C.
// - The guard value is nine bits, its top bit in bit 7 of the block guard register.
// - The first sent character waits the block guard time after the last received start.
module scgt_timers #(
  parameter int BW_WIDTH = scgt_pkg::BW_W,
  parameter int CW_WIDTH = scgt_pkg::CW_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic etu_tick,
  input wire logic mode_t1,
  input wire logic tx_mode,
  input wire logic tx_start,
  input wire logic rx_start,
  input wire logic card_break,
  output logic tx_hold,
  output logic bw_timeout,
  output logic cw_timeout,
  output logic timer_irq
);
  typedef struct packed {
    logic [7:0] xguard;
    logic [7:0] bguard;
    logic [27:0] bw;
    logic [15:0] cw;
    logic [7:0] rdata;
    logic [8:0] gcnt;
    logic [4:0] bcnt;
    logic last_rx;
    logic hold;
    logic bwto;
    logic cwto;
    logic irq;
  } scgt_st_t;
  scgt_st_t st_r;
  scgt_st_t st_nxt;

  logic bw_tout;
  logic cw_tout;
  logic [8:0] guard_eff;

  // Saturating add used by the guard spacing counter gcnt.
  function automatic logic [8:0] sat_inc(input logic [8:0] v, input logic tick);
    sat_inc = (tick && v != 9'h1FF) ? 9'(v + 9'h001) : v;
  endfunction : sat_inc

  always_comb begin
    guard_eff = {st_r.bguard[scgt_pkg::XGUARD_MSB_BIT], st_r.xguard};
    if (!mode_t1 && guard_eff < scgt_pkg::XGUARD_MIN_T0) begin
      guard_eff = scgt_pkg::XGUARD_MIN_T0;
    end else if (mode_t1 && guard_eff < scgt_pkg::XGUARD_MIN_T1) begin
      guard_eff = scgt_pkg::XGUARD_MIN_T1;
    end
  end

  // Register writes, read mux and the spacing holds for the transmitter.
  always_comb begin
    st_nxt = st_r;
    st_nxt.bwto = bw_tout;
    st_nxt.cwto = cw_tout;
    st_nxt.irq = bw_tout | cw_tout;
    if (reg_wr) begin
      case (reg_addr)
        scgt_pkg::ADDR_XGUARD: st_nxt.xguard = reg_wdata;
        scgt_pkg::ADDR_BGUARD: st_nxt.bguard = reg_wdata;
        scgt_pkg::ADDR_BW3: st_nxt.bw[27:24] = reg_wdata[3:0] & scgt_pkg::BW3_MASK;
        scgt_pkg::ADDR_BW2: st_nxt.bw[23:16] = reg_wdata;
        scgt_pkg::ADDR_BW1: st_nxt.bw[15:8] = reg_wdata;
        scgt_pkg::ADDR_BW0: st_nxt.bw[7:0] = reg_wdata;
        scgt_pkg::ADDR_CWH: st_nxt.cw[15:8] = reg_wdata;
        scgt_pkg::ADDR_CWL: st_nxt.cw[7:0] = reg_wdata;
        default: st_nxt.xguard = st_r.xguard;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        scgt_pkg::ADDR_XGUARD: st_nxt.rdata = st_r.xguard;
        scgt_pkg::ADDR_BGUARD: st_nxt.rdata = st_r.bguard;
        scgt_pkg::ADDR_BW3: st_nxt.rdata = {4'h0, st_r.bw[27:24]};
        scgt_pkg::ADDR_BW2: st_nxt.rdata = st_r.bw[23:16];
        scgt_pkg::ADDR_BW1: st_nxt.rdata = st_r.bw[15:8];
        scgt_pkg::ADDR_BW0: st_nxt.rdata = st_r.bw[7:0];
        scgt_pkg::ADDR_CWH: st_nxt.rdata = st_r.cw[15:8];
        scgt_pkg::ADDR_CWL: st_nxt.rdata = st_r.cw[7:0];
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (tx_start) begin
      st_nxt.gcnt = 9'h000;
      st_nxt.last_rx = 1'b0;
    end else begin
      st_nxt.gcnt = sat_inc(st_r.gcnt, etu_tick);
    end
    if (rx_start) begin
      st_nxt.bcnt = 5'h00;
      st_nxt.last_rx = 1'b1;
    end else if (etu_tick && st_r.bcnt != 5'h1F) begin
      st_nxt.bcnt = 5'(st_r.bcnt + 5'h01);
    end
    st_nxt.hold = 1'b0;
    if (tx_mode && st_nxt.gcnt < guard_eff) begin
      st_nxt.hold = 1'b1;
    end
    if (st_nxt.last_rx && 9'(st_nxt.bcnt) < 9'(st_r.bguard[scgt_pkg::BGUARD_W-1:0])) begin
      st_nxt.hold = 1'b1;
    end
    if (!mode_t1 && card_break) begin
      st_nxt.hold = 1'b1;
    end
  end

  scgt_etu_timer #(.W(BW_WIDTH)) u_bw (
    .clk(clk),
    .sys_rst(sys_rst),
    .etu_tick(etu_tick),
    .arm(tx_start),
    .restart(!mode_t1 && rx_start),
    .stop(mode_t1 && rx_start),
    .limit(st_r.bw[BW_WIDTH-1:0]),
    .timeout(bw_tout)
  );

  scgt_etu_timer #(.W(CW_WIDTH)) u_cw (
    .clk(clk),
    .sys_rst(sys_rst),
    .etu_tick(etu_tick),
    .arm(1'b0),
    .restart(rx_start),
    .stop(tx_start),
    .limit(st_r.cw[CW_WIDTH-1:0]),
    .timeout(cw_tout)
  );

  // State register with documented reset values.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.xguard <= scgt_pkg::XGUARD_RST;
      st_r.bguard <= scgt_pkg::BGUARD_RST;
      st_r.gcnt <= 9'h1FF;
      st_r.bcnt <= 5'h1F;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign tx_hold = st_r.hold;
  assign bw_timeout = st_r.bwto;
  assign cw_timeout = st_r.cwto;
  assign timer_irq = st_r.irq;
endmodule : scgt_timers

// *** test/scgt_timers_asserts.sv ***
/* Checker for the guard and waiting timers.
   Sees only the top ports; bound from the bench top. */
`timescale 1ns/1ns
module scgt_timers_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic etu_tick,
  input wire logic mode_t1,
  input wire logic tx_mode,
  input wire logic tx_start,
  input wire logic rx_start,
  input wire logic card_break,
  input wire logic tx_hold,
  input wire logic bw_timeout,
  input wire logic cw_timeout,
  input wire logic timer_irq
);
  logic seen_r;
  logic [8:0] tk_r;
  // Ticks since the last sent start; the floor is judged one tick short to allow for lag.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_r <= 1'b0;
      tk_r <= 9'h000;
    end else if (tx_start) begin
      seen_r <= 1'b1;
      tk_r <= 9'h000;
    end else if (etu_tick && tk_r != 9'h1FF) begin
      tk_r <= tk_r + 9'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_irq_or: assert property (timer_irq == (bw_timeout | cw_timeout))
    else $error("irq differs from the timeouts");
  a_cw_pulse: assert property (cw_timeout |=> !cw_timeout)
    else $error("cw timeout wider than one cycle");
  a_cw_tick: assert property (cw_timeout |-> $past(etu_tick, 2))
    else $error("cw timeout not after a tick");
  a_bw_tick: assert property (bw_timeout |-> $past(etu_tick, 2))
    else $error("bw timeout not after a tick");
  a_hold_floor: assert property (seen_r && tx_mode && tk_r < 9'h00A |=> tx_hold)
    else $error("guard released too early");
  a_top_nibble: assert property (reg_rd && reg_addr == 16'hFE18 |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved nibble not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 16'hFE1D |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  cp_cw: cover property (cw_timeout);
  cp_bw: cover property (bw_timeout);
  cp_brk: cover property (card_break && tx_hold);
endmodule : scgt_timers_asserts

// *** test/scgt_card_model.sv ***
/* Card side of the link: replies with a received start bit on an ETU boundary.
   Assumes the bench asks with one-cycle rx_go and holds brk_go as a level. */
`timescale 1ns/1ns
module scgt_card_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic etu_tick,
  input wire logic rx_go,
  input wire logic brk_go,
  output logic rx_start,
  output logic card_break
);
  logic pend_r;
  // A real card only starts a character on its own bit grid, so replies wait for a tick.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r <= 1'b0;
      rx_start <= 1'b0;
      card_break <= 1'b0;
    end else begin
      pend_r <= (pend_r | rx_go) & ~etu_tick;
      rx_start <= (pend_r | rx_go) & etu_tick;
      card_break <= brk_go;
    end
  end
endmodule : scgt_card_model

// *** test/scgt_timers_tb_top.sv ***
/* Bench top: register tasks, a card model and tick-counting tests.
   Assumes package, design, checker and card model are compiled first. */
`timescale 1ns/1ns
module scgt_timers_tb_top;
  logic clk, sys_rst, reg_wr, reg_rd, etu_tick, mode_t1, tx_mode, tx_start, rx_go, brk_go;
  logic rx_start, card_break, tx_hold, bw_timeout, cw_timeout, timer_irq;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] div_r;
  int fails, n_tests, n;
  int gx[5] = '{12, 11, 20, 20, 256};
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
  scgt_timers i_scgt_timers (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .etu_tick, .mode_t1, .tx_mode, .tx_start, .rx_start, .card_break, .tx_hold,
    .bw_timeout, .cw_timeout, .timer_irq);
  scgt_card_model i_scgt_card_model (.clk, .sys_rst, .etu_tick, .rx_go, .brk_go, .rx_start,
    .card_break);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // One ETU every four clocks keeps the long guard case short.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 2'h0;
      etu_tick <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      etu_tick <= (div_r == 2'h3);
    end
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  // Starts a sent or received character just after a tick, then lets the design react.
  task automatic kick(input bit tx);
    @(negedge clk);
    while (!etu_tick) @(negedge clk);
    @(posedge clk);
    tx_start <= tx;
    rx_go <= !tx;
    @(posedge clk);
    tx_start <= 1'b0;
    rx_go <= 1'b0;
    if (!tx) begin
      @(negedge clk);
      while (!rx_start) @(negedge clk);
    end
    @(posedge clk);
  endtask : kick
  // Counts ticks until the hold drops (0) or a timeout pulses (1 cw, 2 bw).
  task automatic watch(input int sel);
    n = 0;
    repeat (1200) begin
      @(negedge clk);
      if (sel == 0 ? !tx_hold : (sel == 1 ? cw_timeout : bw_timeout) === 1'b1) break;
      n += int'(etu_tick);
    end
  endtask : watch
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    {reg_wr, reg_rd, tx_start, rx_go, brk_go, mode_t1} = '0;
    {reg_addr, reg_wdata, fails, n_tests} = '0;
    sys_rst = 1'b1;
    tx_mode = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(16'hFE16 + 16'(i), i == 0 ? 8'h10 : i == 1 ? 8'h0C : 8'h00);
    for (int i = 2; i < 8; i++) wr(16'hFE16 + 16'(i), 8'hEF + 8'(i));
    for (int i = 2; i < 8; i++) rd(16'hFE16 + 16'(i), i == 2 ? 8'h01 : 8'hEF + 8'(i));
    wr(16'hFE30, 8'h55);
    rd(16'hFE30, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      mode_t1 <= 1'(i % 2);
      wr(16'hFE16, {i == 4, 7'h10});
      wr(16'hFE17, i == 4 ? 8'h00 : i < 2 ? 8'h02 : 8'h14);
      kick(1);
      watch(0);
      `CHK("guard_etus", gx[i], n)
    end
    wr(16'hFE16, 8'h10);
    kick(0);
    @(posedge clk);
    watch(0);
    `CHK("block_guard", 16, n)
    @(posedge clk);
    mode_t1 <= 1'b0;
    brk_go <= 1'b1;
    repeat (80) @(posedge clk);
    @(negedge clk);
    `CHK("break_hold", 1'b1, tx_hold)
    @(posedge clk);
    brk_go <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK("break_free", 1'b0, tx_hold)
    $display("test guard done");
    @(posedge clk);
    tx_mode <= 1'b0;
    wr(16'hFE1C, 8'h00);
    wr(16'hFE1D, 8'h03);
    kick(0);
    kick(0);
    watch(1);
    `CHK("cw_etus", 3, n)
    wr(16'hFE1D, 8'h00);
    for (int i = 0; i < 4; i++) wr(16'hFE18 + 16'(i), i == 3 ? 8'h05 : 8'h00);
    mode_t1 <= 1'b1;
    kick(1);
    watch(2);
    `CHK("bw_etus", 5, n)
    kick(1);
    kick(0);
    watch(2);
    `CHK("bw_stopped", 300, n)
    @(posedge clk);
    mode_t1 <= 1'b0;
    kick(0);
    watch(2);
    `CHK("ww_etus", 5, n)
    $display("test timers done");
    finish_test();
  end
  initial begin
    #1000000;
    fails++;
    finish_test();
  end
endmodule : scgt_timers_tb_top
bind scgt_timers scgt_timers_asserts i_scgt_timers_asserts (.clk, .sys_rst, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .etu_tick, .mode_t1, .tx_mode, .tx_start, .rx_start,
  .card_break, .tx_hold, .bw_timeout, .cw_timeout, .timer_irq);
